// file: shared/mode_busy_if.sv
// Link between the transceiver and its host: two mode pins, busy line and
// one byte strobe in each direction standing in for the serial port.
// Assumes both ends share clk.
interface mode_busy_if;
  logic       mode_select_hi;
  logic       mode_select_lo;
  logic       busy_indicator;
  logic [7:0] host_byte;
  logic       host_byte_valid;
  logic [7:0] dev_byte;
  logic       dev_byte_valid;

  modport device (
    input  mode_select_hi,
    input  mode_select_lo,
    input  host_byte,
    input  host_byte_valid,
    output busy_indicator,
    output dev_byte,
    output dev_byte_valid
  );

  modport host (
    output mode_select_hi,
    output mode_select_lo,
    output host_byte,
    output host_byte_valid,
    input  busy_indicator,
    input  dev_byte,
    input  dev_byte_valid
  );
endinterface : mode_busy_if

// file: shared/mode_busy_pkg.sv
// Constants shared by the transceiver mode/busy logic and its host controller.
// Assumes a single 200 MHz clock on both ends.
package mode_busy_pkg;

  // ----------------------------------------------------------------
  // Modes, as seen on {mode_select_hi, mode_select_lo}
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_WAKE        = 2'h1;
  localparam logic [1:0] MODE_CONFIG      = 2'h2;
  localparam logic [1:0] MODE_SLEEP       = 2'h3;

  // ----------------------------------------------------------------
  // Buffer and addressing
  // ----------------------------------------------------------------
  localparam int          BUF_DEPTH    = 1000;
  localparam logic [9:0]  BUF_LAST     = 10'h3e7;
  localparam logic [9:0]  BUF_FULL     = 10'h3e8;
  localparam logic [7:0]  PKT_LAST     = 8'hef;
  localparam logic [15:0] BCAST_ADDR   = 16'hffff;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [1:0]  CFG_IDX_ROLE = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int SELFTEST_TIME_US = 100;
  localparam int SWITCH_TIME_US   = 1000;
  localparam int SETTLE_TIME_US   = 2000;
  localparam int GAP_TIME_US      = 50;
  localparam int SELFTEST_CYC     = SELFTEST_TIME_US * CLK_MHZ;
  localparam int SWITCH_CYC       = SWITCH_TIME_US * CLK_MHZ;
  localparam int SETTLE_CYC       = SETTLE_TIME_US * CLK_MHZ;
  localparam int GAP_CYC          = GAP_TIME_US * CLK_MHZ;
  localparam logic [7:0] OUT_CYC  = 8'h10;

  // ----------------------------------------------------------------
  // Host controller register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TXDATA = 4'h8;
  localparam logic [3:0] REG_RXDATA = 4'hc;
  localparam logic [1:0] CTRL_RESET = MODE_TRANSPARENT;

endpackage : mode_busy_pkg

// file: test/mode_busy_chk.sv
// Concurrent checks on the link between the transceiver end and the host end.
// Assumes one clock and a synchronous active-high reset shared by both ends.
module mode_busy_chk #(
  parameter int SELFTEST_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       mode_select_hi,
  input wire logic       mode_select_lo,
  input wire logic       busy_indicator,
  input wire logic [7:0] host_byte,
  input wire logic       host_byte_valid,
  input wire logic [7:0] dev_byte,
  input wire logic       dev_byte_valid
);
  localparam int BOOT_MAX = SELFTEST_CYCLES + 8;
  logic [7:0] slp_q;
  logic       seen_q;
  logic       long_sleep;

  // Sleep counts as settled once the pins have asked for it for 64 idle cycles.
  assign long_sleep = slp_q >= 8'h40;

  always_ff @(posedge clk)
  begin
    if (rst || !(mode_select_hi && mode_select_lo))
      slp_q <= 8'h00;
    else if (busy_indicator && !long_sleep)
      slp_q <= slp_q + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      seen_q <= 1'b0;
    else if (busy_indicator)
      seen_q <= 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence boot_start;
    $fell(rst);
  endsequence
  sequence leave_sleep;
    $past(long_sleep) && !(mode_select_hi && mode_select_lo);
  endsequence
  sequence selftest_low;
    !busy_indicator [*8];
  endsequence

  a_boot_low: assert property (boot_start |-> selftest_low)
    else $error("busy high during power-up self-test");
  a_boot_rise: assert property (boot_start |-> ##[1:BOOT_MAX] busy_indicator)
    else $error("busy did not rise after self-test");
  a_push_low: assert property (host_byte_valid && !mode_select_hi |-> ##2 !busy_indicator)
    else $error("busy high with a byte in the buffer");
  a_out_low: assert property (dev_byte_valid |-> !busy_indicator && !$past(busy_indicator, 4))
    else $error("busy high while serial output active");
  a_dev_gap: assert property (dev_byte_valid |=> !dev_byte_valid [*8])
    else $error("serial output bytes too close");
  a_sleep_quiet: assert property (long_sleep |-> !dev_byte_valid)
    else $error("serial output during deep sleep");
  a_wake_test: assert property (leave_sleep |-> ##[1:12] selftest_low)
    else $error("no self-test on leaving sleep");
  a_host_waits: assert property (host_byte_valid |-> seen_q)
    else $error("host sent before busy rose");
endmodule : mode_busy_chk

// file: test/tb.sv
// Testbench: transceiver and host joined by the link, host driven over AHB-Lite.
// Assumes short sim counts: self-test 20, switch 30, gap 8, settle 40 cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] STAT_A = {4'h0, mode_busy_pkg::REG_STATUS};
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, src, stall;
  logic        tx_valid, tx_last, tx_ready, tx_wake, rx_valid, radio_on, sleeping, role;
  logic [1:0]  htrans, mode;
  logic [2:0]  hsize;
  logic [7:0]  tx_data, rx_data;
  logic [15:0] tx_addr, rx_dest;
  logic [31:0] haddr, hwdata, hrdata, rd_v, st, r;
  logic [63:0] ck_e;
  logic [8:0]  q_tx[$];
  logic [7:0]  q_dev[$];
  logic [63:0] q_ck[$];
  integer      seed = 46;
  int          err_count = 0, num_checks = 0, cyc = 0;
  event        chk_ev;

  mode_busy_if lnk ();
  mode_busy_device #(.SELFTEST_CYCLES(20), .SWITCH_CYCLES(30), .GAP_CYCLES(8)) mode_busy_device_inst (
    .clk(clk), .rst(rst), .link(lnk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_addr(tx_addr), .tx_wake(tx_wake), .rx_data(rx_data), .rx_dest(rx_dest),
    .rx_valid(rx_valid), .mode(mode), .radio_on(radio_on), .sleeping(sleeping), .wake_role_tx(role));
  mode_busy_host #(.SETTLE_CYCLES(40)) mode_busy_host_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(lnk));
  mode_busy_chk #(.SELFTEST_CYCLES(20)) mode_busy_chk_inst (
    .clk(clk), .rst(rst), .mode_select_hi(lnk.mode_select_hi), .mode_select_lo(lnk.mode_select_lo),
    .busy_indicator(lnk.busy_indicator), .host_byte(lnk.host_byte), .host_byte_valid(lnk.host_byte_valid),
    .dev_byte(lnk.dev_byte), .dev_byte_valid(lnk.dev_byte_valid));

  assign st = {10'h0, mode, radio_on, sleeping, tx_wake, role, tx_addr};

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task tally_and_finish;
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tx_ready <= !stall && (($random(seed) & 3) != 0);
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      cmp({23'h0, tx_last, tx_data}, q_tx.size() ? {23'h0, q_tx.pop_front()} : 32'hdead);
    if (lnk.dev_byte_valid === 1'b1)
      cmp({24'h0, lnk.dev_byte}, q_dev.size() ? {24'h0, q_dev.pop_front()} : 32'hdead);
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  always @(chk_ev)
  begin
    ck_e = q_ck.pop_front();
    cmp((src ? st : rd_v) & ck_e[31:0], ck_e[63:32] & ck_e[31:0]);
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask : ahb

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, a, 32'h0, rd_v);
    src = 1'b0;
    q_ck.push_back({e, m});
    -> chk_ev;
  endtask : rd

  task probe(input logic [31:0] e, input logic [31:0] m);
    repeat (2) @(posedge clk);
    #1;
    src = 1'b1;
    q_ck.push_back({e, m});
    -> chk_ev;
  endtask : probe

  function automatic logic [31:0] stv(input logic [1:0] m, input logic [3:0] f, input logic [15:0] a);
    return {10'h0, m, f, a};
  endfunction : stv

  task put(input logic [7:0] b, input logic last, input logic keep);
    ahb(1'b1, {4'h0, mode_busy_pkg::REG_TXDATA}, {24'h0, b}, r);
    if (keep)
      q_tx.push_back({last, b});
  endtask : put

  task ctl(input logic [1:0] m);
    ahb(1'b1, {4'h0, mode_busy_pkg::REG_CTRL}, {30'h0, m}, r);
  endtask : ctl

  task wait_for(input logic sel, input logic [1:0] v, input int n);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < n && !ok; i++)
    begin
      @(posedge clk);
      #1;
      ok = ((sel ? mode : {1'b0, lnk.busy_indicator}) === v);
    end
    cmp({31'h0, ok}, 32'h1);
  endtask : wait_for

  task rx(input logic [15:0] dst, input logic keep);
    logic [7:0] b;
    b = 8'($random(seed));
    @(posedge clk);
    rx_data <= b;
    rx_dest <= dst;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    if (keep)
      q_dev.push_back(b);
    repeat (3) @(posedge clk);
    wait_for(1'b0, 2'h1, 60);
    if (keep)
      rd({4'h0, mode_busy_pkg::REG_RXDATA}, {24'h0, b}, 32'h000000ff);
  endtask : rx

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {hsel, hwrite, rx_valid, stall, tx_ready} = 5'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {rx_data, rx_dest} = 24'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_for(1'b0, 2'h1, 60);
    wait_for(1'b1, mode_busy_pkg::MODE_TRANSPARENT, 10);
    probe(stv(2'h0, 4'h8, 16'h0), 32'h003effff);
    rd(STAT_A, 32'h3, 32'h3);
    rd(8'h10, 32'h0, 32'hffffffff);
    for (int i = 0; i < 245; i++)
      put(8'($random(seed)), (i % 240 == 239) || (i == 244), 1'b1);
    wait_for(1'b0, 2'h1, 900);
    rd(STAT_A, 32'h1, 32'h11);
    rx(16'h0000, 1'b1);
    rx(16'h1234, 1'b0);
    rx(mode_busy_pkg::BCAST_ADDR, 1'b1);
    ctl(2'h2);
    wait_for(1'b1, 2'h2, 12);
    put(8'hff, 1'b0, 1'b0);
    put(8'hff, 1'b0, 1'b0);
    put(8'h01, 1'b0, 1'b0);
    wait_for(1'b0, 2'h1, 60);
    probe(stv(2'h2, 4'h1, 16'hffff), 32'h003fffff);
    ctl(2'h1);
    wait_for(1'b1, 2'h1, 12);
    probe(stv(2'h1, 4'hb, 16'hffff), 32'h003fffff);
    ctl(2'h0);
    wait_for(1'b1, 2'h0, 12);
    rx(16'h1234, 1'b1);
    stall <= 1'b1;
    for (int i = 0; i < 3; i++)
      put(8'($random(seed)), i == 2, 1'b1);
    rd(STAT_A, 32'h0, 32'h1);
    ctl(2'h3);
    repeat (40) @(posedge clk);
    probe(stv(2'h0, 4'h0, 16'h0), 32'h00300000);
    stall <= 1'b0;
    wait_for(1'b0, 2'h1, 100);
    wait_for(1'b1, 2'h3, 45);
    rd(STAT_A, 32'h0, 32'h4);
    repeat (45) @(posedge clk);
    rd(STAT_A, 32'h4, 32'h4);
    probe(stv(2'h3, 4'h5, 16'hffff), 32'h003fffff);
    repeat (70) @(posedge clk);
    rx(16'hffff, 1'b0);
    ctl(2'h0);
    wait_for(1'b0, 2'h0, 12);
    wait_for(1'b0, 2'h1, 60);
    wait_for(1'b1, 2'h0, 40);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_for(1'b0, 2'h1, 60);
    probe(stv(2'h0, 4'h8, 16'h0), 32'h003effff);
    cmp(32'(q_tx.size() + q_dev.size()), 32'h0);
    tally_and_finish;
  end
endmodule : tb

// file: verilog/mode_busy_device.sv
// Transceiver end: mode decode, transmit buffer, serial output and busy line.
// Assumes link inputs synchronous to clk except the mode pins, and a radio
// that accepts bytes on tx_valid/tx_ready and delivers them on rx_valid.
module mode_busy_device #(
  parameter int SELFTEST_CYCLES = mode_busy_pkg::SELFTEST_CYC,
  parameter int SWITCH_CYCLES   = mode_busy_pkg::SWITCH_CYC,
  parameter int GAP_CYCLES      = mode_busy_pkg::GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  mode_busy_if.device      link,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic      [15:0] tx_addr,
  output logic             tx_wake,
  input  wire logic [7:0]  rx_data,
  input  wire logic [15:0] rx_dest,
  input  wire logic        rx_valid,
  output logic      [1:0]  mode,
  output logic             radio_on,
  output logic             sleeping,
  output logic             wake_role_tx
);

  typedef enum logic [1:0] {S_INIT, S_RUN, S_WAIT} state_t;

  // ----------------------------------------------------------------
  // Mode pin synchroniser
  // ----------------------------------------------------------------
  logic [1:0] pins_meta_q;
  logic [1:0] pins_q;

  always_ff @(posedge clk)
  begin
    pins_meta_q <= {link.mode_select_hi, link.mode_select_lo};
    pins_q      <= pins_meta_q;
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  state_t      state_q;
  logic [21:0] tmr_q;
  logic        hold_q;
  logic        any_busy;
  logic [9:0]  cnt_q;
  logic        rx_pend_q;
  logic        out_act_q;

  assign any_busy = (state_q != S_RUN) || (cnt_q != 10'h000) || rx_pend_q || out_act_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= S_INIT;
      tmr_q   <= 22'h000000;
      mode    <= mode_busy_pkg::MODE_SLEEP;
      hold_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_INIT:
        begin
          if (tmr_q == 22'(SELFTEST_CYCLES - 1))
          begin
            state_q <= S_RUN;
            mode    <= pins_q;
            tmr_q   <= 22'h000000;
            hold_q  <= 1'b0;
          end
          else
          begin
            tmr_q <= tmr_q + 22'h000001;
          end
        end
        S_RUN:
        begin
          if (link.busy_indicator == 1'b0)
          begin
            hold_q <= 1'b1;
          end
          else if (pins_q == mode)
          begin
            hold_q <= 1'b0;
          end
          // Pins are looked at only while the line is high and nothing is pending.
          if (link.busy_indicator && !any_busy && pins_q != mode)
          begin
            if (mode == mode_busy_pkg::MODE_SLEEP)
            begin
              state_q <= S_INIT;
              tmr_q   <= 22'h000000;
            end
            else if (hold_q)
            begin
              state_q <= S_WAIT;
              tmr_q   <= 22'h000000;
            end
            else
            begin
              mode <= pins_q;
            end
          end
        end
        S_WAIT:
        begin
          if (tmr_q == 22'(SWITCH_CYCLES - 1))
          begin
            state_q <= S_RUN;
            mode    <= pins_q;
            hold_q  <= 1'b0;
          end
          else
          begin
            tmr_q <= tmr_q + 22'h000001;
          end
        end
        default:
        begin
          state_q <= S_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.busy_indicator <= 1'b0;
    end
    else
    begin
      link.busy_indicator <= !any_busy;
    end
  end

  logic run_q;
  assign run_q = (state_q == S_RUN);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      radio_on <= 1'b0;
      sleeping <= 1'b0;
      tx_wake  <= 1'b0;
    end
    else
    begin
      radio_on <= run_q && !mode[1];
      sleeping <= run_q && (mode == mode_busy_pkg::MODE_SLEEP);
      tx_wake  <= run_q && (mode == mode_busy_pkg::MODE_WAKE) && wake_role_tx;
    end
  end

  // ----------------------------------------------------------------
  // Configuration writes in mode 2
  // ----------------------------------------------------------------
  logic [1:0] cfg_idx_q;
  logic       cfg_mode;
  logic       data_mode;

  assign cfg_mode  = run_q && (mode == mode_busy_pkg::MODE_CONFIG);
  assign data_mode = run_q && !mode[1];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_idx_q    <= 2'h0;
      tx_addr      <= mode_busy_pkg::ADDR_RESET;
      wake_role_tx <= 1'b0;
    end
    else if (!cfg_mode)
    begin
      cfg_idx_q <= 2'h0;
    end
    else if (link.host_byte_valid)
    begin
      case (cfg_idx_q)
        2'h0:    tx_addr[15:8] <= link.host_byte;
        2'h1:    tx_addr[7:0]  <= link.host_byte;
        default: wake_role_tx  <= link.host_byte[0];
      endcase
      cfg_idx_q <= (cfg_idx_q == mode_busy_pkg::CFG_IDX_ROLE) ? 2'h0 : cfg_idx_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer and packetiser
  // ----------------------------------------------------------------
  logic [7:0]  buf_mem [mode_busy_pkg::BUF_DEPTH];
  logic [9:0]  wr_q;
  logic [9:0]  rd_q;
  logic [21:0] gap_q;
  logic [7:0]  pkt_q;
  logic        push;
  logic        pop;

  function automatic logic [9:0] next_ptr(input logic [9:0] p);
    next_ptr = (p == mode_busy_pkg::BUF_LAST) ? 10'h000 : p + 10'h001;
  endfunction : next_ptr

  assign push = data_mode && link.host_byte_valid && (cnt_q != mode_busy_pkg::BUF_FULL);
  assign pop  = (gap_q == 22'(GAP_CYCLES)) && (cnt_q != 10'h000) && (!tx_valid || tx_ready);

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      buf_mem[wr_q] <= link.host_byte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q  <= 10'h000;
      rd_q  <= 10'h000;
      cnt_q <= 10'h000;
      gap_q <= 22'h000000;
    end
    else
    begin
      if (push)
      begin
        wr_q <= next_ptr(wr_q);
      end
      if (pop)
      begin
        rd_q <= next_ptr(rd_q);
      end
      cnt_q <= cnt_q + {9'h000, push} - {9'h000, pop};
      // Draining starts after a quiet gap, or at once when the buffer is full.
      if (push && cnt_q != mode_busy_pkg::BUF_LAST)
      begin
        gap_q <= 22'h000000;
      end
      else if (push || gap_q == 22'(GAP_CYCLES - 1))
      begin
        gap_q <= 22'(GAP_CYCLES);
      end
      else if (gap_q != 22'(GAP_CYCLES))
      begin
        gap_q <= gap_q + 22'h000001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      pkt_q    <= 8'h00;
    end
    else if (pop)
    begin
      tx_valid <= 1'b1;
      tx_data  <= buf_mem[rd_q];
      tx_last  <= (pkt_q == mode_busy_pkg::PKT_LAST) || (cnt_q == 10'h001);
      pkt_q    <= (pkt_q == mode_busy_pkg::PKT_LAST || cnt_q == 10'h001) ? 8'h00 : pkt_q + 8'h01;
    end
    else if (tx_ready)
    begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Radio receive, address filter and serial output
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_CYC_M1 = mode_busy_pkg::OUT_CYC - 8'h01;

  logic [7:0] rx_hold_q;
  logic [7:0] out_tmr_q;
  logic       rx_take;

  assign rx_take = data_mode && rx_valid && !rx_pend_q
                   && (rx_dest == tx_addr || rx_dest == mode_busy_pkg::BCAST_ADDR
                       || tx_addr == mode_busy_pkg::BCAST_ADDR);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_pend_q           <= 1'b0;
      rx_hold_q           <= 8'h00;
      out_act_q           <= 1'b0;
      out_tmr_q           <= 8'h00;
      link.dev_byte       <= 8'h00;
      link.dev_byte_valid <= 1'b0;
    end
    else
    begin
      link.dev_byte_valid <= 1'b0;
      if (rx_take)
      begin
        rx_pend_q <= 1'b1;
        rx_hold_q <= rx_data;
      end
      else if (rx_pend_q && !out_act_q)
      begin
        out_act_q <= 1'b1;
        out_tmr_q <= 8'h00;
      end
      else if (out_act_q)
      begin
        if (out_tmr_q == OUT_CYC_M1)
        begin
          out_act_q           <= 1'b0;
          rx_pend_q           <= 1'b0;
          link.dev_byte       <= rx_hold_q;
          link.dev_byte_valid <= 1'b1;
        end
        else
        begin
          out_tmr_q <= out_tmr_q + 8'h01;
        end
      end
    end
  end

endmodule : mode_busy_device

// file: verilog/mode_busy_host.sv
// Host end: an AHB-Lite slave whose registers drive the mode pins, send and
// receive bytes over the link and report the transceiver's busy state.
// Assumes the link signals are synchronous to clk.
module mode_busy_host #(
  parameter int SETTLE_CYCLES = mode_busy_pkg::SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  mode_busy_if.host        link
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       wr_q;
  logic [3:0] addr_q;
  logic       ph_take;
  logic [1:0] mode_q;
  logic       online_q;
  logic       settled_q;
  logic       rx_flag_q;
  logic       drop_q;
  logic [7:0] rx_q;
  logic [9:0] burst_q;
  logic       tx_go;
  logic       rx_rd;

  assign ph_take = hsel && htrans[1] && hready;
  assign tx_go   = wr_q && addr_q == mode_busy_pkg::REG_TXDATA && online_q
                   && burst_q != mode_busy_pkg::BUF_LAST;
  assign rx_rd   = ph_take && !hwrite && haddr[3:0] == mode_busy_pkg::REG_RXDATA;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q      <= 1'b0;
      addr_q    <= 4'h0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_q   <= ph_take && hwrite && hsize == 3'h2 && haddr[31:4] == 28'h0000000;
      addr_q <= haddr[3:0];
      if (ph_take && !hwrite)
      begin
        case (haddr[31:0])
          {28'h0000000, mode_busy_pkg::REG_CTRL}:   hrdata <= {30'h00000000, mode_q};
          {28'h0000000, mode_busy_pkg::REG_STATUS}:
            hrdata <= {27'h0000000, drop_q, rx_flag_q, settled_q, online_q, link.busy_indicator};
          {28'h0000000, mode_busy_pkg::REG_RXDATA}: hrdata <= {24'h000000, rx_q};
          default:                                  hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode pins, readiness and settling
  // ----------------------------------------------------------------
  logic        busy_prev_q;
  logic [21:0] settle_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q              <= mode_busy_pkg::CTRL_RESET;
      link.mode_select_hi <= 1'b0;
      link.mode_select_lo <= 1'b0;
      busy_prev_q         <= 1'b0;
      online_q            <= 1'b0;
      settle_q            <= 22'h000000;
      settled_q           <= 1'b0;
    end
    else
    begin
      busy_prev_q <= link.busy_indicator;
      if (link.busy_indicator && !busy_prev_q)
      begin
        online_q <= 1'b1;
      end
      if (wr_q && addr_q == mode_busy_pkg::REG_CTRL)
      begin
        mode_q              <= hwdata[1:0];
        link.mode_select_hi <= hwdata[1];
        link.mode_select_lo <= hwdata[0];
        settle_q            <= 22'h000000;
        settled_q           <= 1'b0;
      end
      else if (!link.busy_indicator)
      begin
        settle_q  <= 22'h000000;
        settled_q <= 1'b0;
      end
      else if (settle_q == 22'(SETTLE_CYCLES - 1))
      begin
        settled_q <= 1'b1;
      end
      else
      begin
        settle_q <= settle_q + 22'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte transfer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.host_byte       <= 8'h00;
      link.host_byte_valid <= 1'b0;
      burst_q              <= 10'h000;
      drop_q               <= 1'b0;
      rx_flag_q            <= 1'b0;
      rx_q                 <= 8'h00;
    end
    else
    begin
      link.host_byte_valid <= tx_go;
      if (tx_go)
      begin
        link.host_byte <= hwdata[7:0];
        burst_q        <= burst_q + 10'h001;
      end
      else if (link.busy_indicator)
      begin
        burst_q <= 10'h000;
      end
      if (wr_q && addr_q == mode_busy_pkg::REG_TXDATA && !tx_go)
      begin
        drop_q <= 1'b1;
      end
      else if (wr_q && addr_q == mode_busy_pkg::REG_STATUS && hwdata[4])
      begin
        drop_q <= 1'b0;
      end
      if (link.dev_byte_valid)
      begin
        rx_flag_q <= 1'b1;
        rx_q      <= link.dev_byte;
      end
      else if (rx_rd)
      begin
        rx_flag_q <= 1'b0;
      end
    end
  end

endmodule : mode_busy_host
